// ===== cct_params.svh
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// Register offsets, one byte register per address
`define CCT_OFS_SC 4'h0
`define CCT_OFS_CNT_HI 4'h1
`define CCT_OFS_CNT_LO 4'h2
`define CCT_OFS_MOD_HI 4'h3
`define CCT_OFS_MOD_LO 4'h4
`define CCT_OFS_CH0_SC 4'h5
`define CCT_OFS_CH0_HI 4'h6
`define CCT_OFS_CH0_LO 4'h7
`define CCT_CH_STRIDE 4'h3

// Timer status and control fields
`define CCT_SC_OVF_FLAG 7
`define CCT_SC_OVF_IE 6
`define CCT_SC_STOP 5
`define CCT_SC_CNT_RST 4
`define CCT_SC_PS_HI 2
`define CCT_SC_PS_LO 0

// Channel status and control fields
`define CCT_CS_FLAG 7
`define CCT_CS_IE 6
`define CCT_CS_BUF 5
`define CCT_CS_UNB 4
`define CCT_CS_ELS_HI 3
`define CCT_CS_ELS_LO 2
`define CCT_CS_TOV 1

// Reset values and prescaler limits
`define CCT_MOD_RST 16'hFFFF
`define CCT_CNT_RST 16'h0000
`define CCT_PS_RST 3'h0
`define CCT_PS_MAX 3'h6
`define CCT_DIV_W 6

`endif

// ===== cct_pkg.sv
package cct_pkg;

  typedef enum logic [1:0] {
    cct_mode_preset = 2'b00,
    cct_mode_capture = 2'b01,
    cct_mode_compare = 2'b11
  } cct_mode_t;

  typedef struct packed {
    logic irq_en;
    logic buf_mode;
    logic unb_mode;
    logic els_hi;
    logic els_lo;
    logic tov;
  } cct_chan_ctrl_t;

  localparam cct_chan_ctrl_t CCT_CTRL_RST = '0;

endpackage : cct_pkg

// ===== cct_timer.sv
// Contract
// RULE1: 16-bit up-counter, free or modulo wrap
// RULE2: Counter readable without disturbing count
// RULE3: Seven prescaler rates from bus clock
// RULE4: Each channel capture or compare independently
// RULE5: Active pin edge copies counter to channel
// RULE6: Capture on every edge, flag ignored
// RULE7: Capture stored two bus cycles after edge
// RULE8: Channel flag raises irq when enabled
// RULE9: Channel value registers untouched by reset
// RULE10: Compare match sets, clears or toggles pin
// RULE11: Unbuffered compare uses written value directly
// RULE12: Software writes values from matching handler
// RULE13: Buffered bit links channels, channel0 first
// RULE14: Last written pair takes over at wrap
// RULE15: Linked: channel1 control unused, pin released
// RULE16: Software writes only the inactive pair
// RULE17: Toggle on wrap makes PWM period
// RULE18: Pulse width from wrap to compare
// RULE19: Modulo 255 gives 256 clock period
// RULE20: Value 128 gives half duty cycle
// RULE21: Overflow flag at modulo, irq when enabled
// RULE22: Buffered bit overrides unbuffered mode bit
// RULE23: Counter returns to zero after modulo
`timescale 1ns/1ps
`include "cct_params.svh"

module cct_timer (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [7:0] bus_rdata,
  input wire logic chan0_pin_in,
  output logic chan0_pin_out,
  output logic chan0_pin_oe,
  input wire logic chan1_pin_in,
  output logic chan1_pin_out,
  output logic chan1_pin_oe,
  output logic chan0_irq,
  output logic chan1_irq,
  output logic overflow_irq
);

  // Timer-wide state
  logic [15:0] cnt_q;
  logic [15:0] mod_q;
  logic [`CCT_DIV_W-1:0] div_q;
  logic [2:0] ps_q;
  logic stop_q;
  logic ovf_q;
  logic ovf_arm_q;
  logic ovf_ie_q;
  logic [7:0] lat_q;
  logic lat_v_q;
  logic [7:0] rdata_q;
  logic act_q;
  logic last_q;
  logic ovf_irq_q;

  // Per-channel state
  cct_pkg::cct_chan_ctrl_t ctl_q [2];
  logic [15:0] val_q [2];
  logic flag_q [2];
  logic arm_q [2];
  logic inh_q [2];
  logic s1_q [2];
  logic s2_q [2];
  logic s3_q [2];
  logic out_q [2];
  logic oe_q [2];
  logic irq_q [2];

  logic pin_in [2];
  logic [7:0] ch_rd [2];
  logic ch_hit [2];
  logic match [2];

  assign pin_in[0] = chan0_pin_in;
  assign pin_in[1] = chan1_pin_in;

  // Bus decode
  wire wr = bus_we;
  wire rd = bus_re;
  wire hit_sc = (bus_addr == `CCT_OFS_SC);
  wire hit_cnt_hi = (bus_addr == `CCT_OFS_CNT_HI);
  wire hit_cnt_lo = (bus_addr == `CCT_OFS_CNT_LO);
  wire hit_mod_hi = (bus_addr == `CCT_OFS_MOD_HI);
  wire hit_mod_lo = (bus_addr == `CCT_OFS_MOD_LO);
  wire sc_wr = wr && hit_sc;
  wire cnt_rst = sc_wr && bus_wdata[`CCT_SC_CNT_RST];

  // Prescaler: rate select picks 1, 2, 4 .. 64 bus clocks per count
  wire [2:0] ps_eff = (ps_q > `CCT_PS_MAX) ? `CCT_PS_MAX : ps_q; // [RULE3]
  wire [`CCT_DIV_W-1:0] ps_one = {{(`CCT_DIV_W-1){1'b0}}, 1'b1};
  wire [`CCT_DIV_W-1:0] ps_mask = `CCT_DIV_W'((ps_one << ps_eff) - ps_one);
  wire tick = !stop_q && ((div_q & ps_mask) == ps_mask); // [RULE3]

  // Counter wraps one count after it reaches the modulo value
  wire wrap = tick && (cnt_q == mod_q); // [RULE1] [RULE21]
  wire [15:0] cnt_nx = wrap ? 16'h0000 : 16'(cnt_q + 16'h0001); // [RULE23]

  wire lnk = ctl_q[0].buf_mode;
  wire [15:0] val_act = act_q ? val_q[1] : val_q[0]; // [RULE14]

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (cnt_rst) begin
      div_q <= '0;
    end else if (!stop_q) begin
      div_q <= `CCT_DIV_W'(div_q + ps_one);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q <= `CCT_CNT_RST;
    end else if (cnt_rst) begin
      cnt_q <= `CCT_CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_nx; // [RULE1] [RULE19]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mod_q <= `CCT_MOD_RST;
    end else if (wr && hit_mod_hi) begin
      mod_q[15:8] <= bus_wdata;
    end else if (wr && hit_mod_lo) begin
      mod_q[7:0] <= bus_wdata;
    end
  end

  // Reading the high byte freezes the low byte for a coherent pair
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lat_q <= 8'h00;
      lat_v_q <= 1'b0;
    end else if (rd && hit_cnt_hi) begin
      lat_q <= cnt_q[7:0]; // [RULE2]
      lat_v_q <= 1'b1;
    end else if (rd && hit_cnt_lo) begin
      lat_v_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ps_q <= `CCT_PS_RST;
      stop_q <= 1'b0;
      ovf_ie_q <= 1'b0;
    end else if (sc_wr) begin
      ps_q <= bus_wdata[`CCT_SC_PS_HI:`CCT_SC_PS_LO];
      stop_q <= bus_wdata[`CCT_SC_STOP];
      ovf_ie_q <= bus_wdata[`CCT_SC_OVF_IE];
    end
  end

  // Flag clears by read with flag set, then write of zero; set wins
  wire ovf_clr = sc_wr && ovf_arm_q && !bus_wdata[`CCT_SC_OVF_FLAG];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ovf_q <= 1'b0;
      ovf_arm_q <= 1'b0;
      ovf_irq_q <= 1'b0;
    end else begin
      ovf_q <= wrap || (ovf_q && !ovf_clr); // [RULE21]
      if (rd && hit_sc && ovf_q) begin
        ovf_arm_q <= 1'b1;
      end else if (sc_wr || wrap) begin
        ovf_arm_q <= 1'b0;
      end
      ovf_irq_q <= (wrap || (ovf_q && !ovf_clr)) && ovf_ie_q; // [RULE21]
    end
  end

  // Buffered pair selection
  wire ch0_sc_wr = wr && (bus_addr == `CCT_OFS_CH0_SC);
  wire buf_on = ch0_sc_wr && bus_wdata[`CCT_CS_BUF] && !lnk;
  wire [3:0] ch1_lo_a = 4'(`CCT_OFS_CH0_LO + `CCT_CH_STRIDE);
  wire ch0_lo_wr = wr && (bus_addr == `CCT_OFS_CH0_LO);
  wire ch1_lo_wr = wr && (bus_addr == ch1_lo_a);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      act_q <= 1'b0;
      last_q <= 1'b0;
    end else if (buf_on) begin
      act_q <= 1'b0; // [RULE13]
      last_q <= 1'b0;
    end else begin
      if (ch1_lo_wr) begin
        last_q <= 1'b1;
      end else if (ch0_lo_wr) begin
        last_q <= 1'b0;
      end
      if (wrap && lnk) begin
        act_q <= ch1_lo_wr ? 1'b1 : (ch0_lo_wr ? 1'b0 : last_q); // [RULE14]
      end
    end
  end

  genvar i;
  for (i = 0; i < 2; i++) begin : g_ch
    localparam logic [3:0] A_SC = 4'(`CCT_OFS_CH0_SC + i * `CCT_CH_STRIDE);
    localparam logic [3:0] A_HI = 4'(`CCT_OFS_CH0_HI + i * `CCT_CH_STRIDE);
    localparam logic [3:0] A_LO = 4'(`CCT_OFS_CH0_LO + i * `CCT_CH_STRIDE);

    // Channel 1 is parked while the pair is linked
    wire off = (i == 1) && lnk; // [RULE15]
    wire buf_ch = (i == 0) && ctl_q[i].buf_mode;
    wire els_any = ctl_q[i].els_hi || ctl_q[i].els_lo;
    cct_pkg::cct_mode_t mode;
    assign mode = (!els_any || off) ? cct_pkg::cct_mode_preset :
                  (buf_ch || ctl_q[i].unb_mode) ? cct_pkg::cct_mode_compare : // [RULE22]
                  cct_pkg::cct_mode_capture; // [RULE4]
    wire is_cmp = (mode == cct_pkg::cct_mode_compare);
    wire is_cap = (mode == cct_pkg::cct_mode_capture);

    wire hsc = (bus_addr == A_SC);
    wire hhi = (bus_addr == A_HI);
    wire hlo = (bus_addr == A_LO);
    wire sc_w = wr && hsc && !off; // [RULE15]

    // Edge detect reads only the second and third stages
    wire rise = s2_q[i] && !s3_q[i];
    wire fall = !s2_q[i] && s3_q[i];
    wire cap_ev = is_cap && !inh_q[i] &&
                  ((ctl_q[i].els_lo && rise) || (ctl_q[i].els_hi && fall)); // [RULE5] [RULE7]

    wire [15:0] cmp_v = buf_ch ? val_act : val_q[i]; // [RULE11] [RULE14]
    assign match[i] = tick && is_cmp && !inh_q[i] && (cnt_nx == cmp_v); // [RULE10] [RULE18]
    wire ev = cap_ev || match[i];
    wire clr = sc_w && arm_q[i] && !bus_wdata[`CCT_CS_FLAG];
    wire flag_nx = ev || (flag_q[i] && !clr);

    assign ch_hit[i] = hsc || hhi || hlo;
    assign ch_rd[i] = hsc ? (off ? 8'h00 : {flag_q[i], ctl_q[i].irq_en,
                              ctl_q[i].buf_mode, ctl_q[i].unb_mode,
                              ctl_q[i].els_hi, ctl_q[i].els_lo,
                              ctl_q[i].tov, 1'b0}) :
                      hhi ? val_q[i][15:8] : val_q[i][7:0];

    always_ff @(posedge ref_clk) begin
      s1_q[i] <= pin_in[i];
      s2_q[i] <= s1_q[i];
      s3_q[i] <= s2_q[i];
    end

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        ctl_q[i] <= cct_pkg::CCT_CTRL_RST;
      end else if (sc_w) begin
        ctl_q[i].irq_en <= bus_wdata[`CCT_CS_IE];
        ctl_q[i].buf_mode <= (i == 0) && bus_wdata[`CCT_CS_BUF]; // [RULE13]
        ctl_q[i].unb_mode <= bus_wdata[`CCT_CS_UNB];
        ctl_q[i].els_hi <= bus_wdata[`CCT_CS_ELS_HI];
        ctl_q[i].els_lo <= bus_wdata[`CCT_CS_ELS_LO];
        ctl_q[i].tov <= bus_wdata[`CCT_CS_TOV];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        flag_q[i] <= 1'b0;
        arm_q[i] <= 1'b0;
        irq_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= flag_nx; // [RULE6]
        if (rd && hsc && flag_q[i]) begin
          arm_q[i] <= 1'b1;
        end else if (sc_w || ev) begin
          arm_q[i] <= 1'b0;
        end
        irq_q[i] <= flag_nx && ctl_q[i].irq_en && !off; // [RULE8]
      end
    end

    // High-byte write (compare) or read (capture) holds off events until the low byte
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        inh_q[i] <= 1'b0;
      end else if ((wr && hhi && is_cmp) || (rd && hhi && is_cap)) begin
        inh_q[i] <= 1'b1;
      end else if ((wr || rd) && hlo) begin
        inh_q[i] <= 1'b0;
      end
    end

    // Value registers carry no reset
    always_ff @(posedge ref_clk) begin
      if (cap_ev) begin
        val_q[i] <= cnt_q; // [RULE5] [RULE6] [RULE9]
      end else if (wr && hhi) begin
        val_q[i][15:8] <= bus_wdata;
      end else if (wr && hlo) begin
        val_q[i][7:0] <= bus_wdata;
      end
    end

    // Wrap toggle outranks a coincident compare
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        out_q[i] <= 1'b1;
        oe_q[i] <= 1'b0;
      end else begin
        oe_q[i] <= is_cmp; // [RULE15]
        if (mode == cct_pkg::cct_mode_preset) begin
          out_q[i] <= !ctl_q[i].unb_mode;
        end else if (is_cmp && wrap && ctl_q[i].tov) begin
          out_q[i] <= !out_q[i]; // [RULE17] [RULE19]
        end else if (match[i]) begin
          if (ctl_q[i].els_hi && ctl_q[i].els_lo) begin
            out_q[i] <= 1'b1; // [RULE10] [RULE18]
          end else if (ctl_q[i].els_hi) begin
            out_q[i] <= 1'b0; // [RULE10] [RULE18] [RULE20]
          end else begin
            out_q[i] <= !out_q[i]; // [RULE10]
          end
        end
      end
    end
  end

  // Read data, valid in the cycle after the strobe
  logic [7:0] rd_d;
  always_comb begin
    rd_d = 8'h00;
    if (hit_sc) begin
      rd_d = {ovf_q, ovf_ie_q, stop_q, 2'b00, ps_q};
    end else if (hit_cnt_hi) begin
      rd_d = cnt_q[15:8]; // [RULE2]
    end else if (hit_cnt_lo) begin
      rd_d = lat_v_q ? lat_q : cnt_q[7:0]; // [RULE2]
    end else if (hit_mod_hi) begin
      rd_d = mod_q[15:8];
    end else if (hit_mod_lo) begin
      rd_d = mod_q[7:0];
    end else if (ch_hit[0]) begin
      rd_d = ch_rd[0];
    end else if (ch_hit[1]) begin
      rd_d = ch_rd[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign bus_rdata = rdata_q;
  assign chan0_pin_out = out_q[0];
  assign chan0_pin_oe = oe_q[0];
  assign chan1_pin_out = out_q[1];
  assign chan1_pin_oe = oe_q[1];
  assign chan0_irq = irq_q[0];
  assign chan1_irq = irq_q[1];
  assign overflow_irq = ovf_irq_q;

endmodule : cct_timer

// ===== cct_timer_props.sv
`timescale 1ns/1ps
module cct_timer_props (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  input wire logic [7:0] bus_rdata,
  input wire logic chan0_pin_out,
  input wire logic chan0_pin_oe,
  input wire logic chan1_pin_oe,
  input wire logic chan0_irq,
  input wire logic chan1_irq,
  input wire logic overflow_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic [7:0] sc_q;
  logic [7:0] c0_q;
  wire logic wr_sc = bus_we && bus_addr == 4'h0;
  wire logic wr_c0 = bus_we && bus_addr == 4'h5;
  wire logic lnk = c0_q[5];
  wire logic pre_hi = c0_q[4:2] == 3'b000;
  wire logic cmp0 = |c0_q[3:2] && |c0_q[5:4];
  wire logic cap0 = |c0_q[3:2] && !(|c0_q[5:4]);
  // Shadows of the controls that steer pins and requests
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sc_q <= 8'h00;
      c0_q <= 8'h00;
    end else begin
      sc_q <= wr_sc ? bus_wdata : sc_q;
      c0_q <= wr_c0 ? bus_wdata : c0_q;
    end
  end
  // Outputs are registered, so a control must stand two cycles
  sequence s_held(b);
    b [*2];
  endsequence
  a_link_pin_free: assert property (s_held(lnk) |-> !chan1_pin_oe)
    else $error("channel 1 pin driven while linked");
  a_link_irq_off: assert property (s_held(lnk) |-> !chan1_irq)
    else $error("channel 1 request while linked");
  a_chan_irq_gate: assert property (s_held(!c0_q[6]) |-> !chan0_irq)
    else $error("channel 0 request while disabled");
  a_ovf_irq_gate: assert property (s_held(!sc_q[6]) |-> !overflow_irq)
    else $error("overflow request while disabled");
  a_capture_no_drive: assert property (cap0 ##1 cap0 |-> !chan0_pin_oe)
    else $error("capture channel drives its pin");
  a_compare_drives: assert property (s_held(cmp0) |-> chan0_pin_oe)
    else $error("compare channel does not drive its pin");
  a_preset_level: assert property (pre_hi [*2] |-> chan0_pin_out && !chan0_pin_oe)
    else $error("preset level wrong");
  a_rdata_slot: assert property (!$past(bus_re) |-> bus_rdata == 8'h00)
    else $error("read data outside its slot");
endmodule : cct_timer_props

bind cct_timer cct_timer_props u_props (.ref_clk(ref_clk), .resetn(resetn),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
  .bus_rdata(bus_rdata), .chan0_pin_out(chan0_pin_out), .chan0_pin_oe(chan0_pin_oe),
  .chan1_pin_oe(chan1_pin_oe), .chan0_irq(chan0_irq), .chan1_irq(chan1_irq),
  .overflow_irq(overflow_irq));

// ===== cct_pin_model.sv
`timescale 1ns/1ps
module cct_pin_model (
  input wire logic lvl0,
  input wire logic lvl1,
  input wire logic out0,
  input wire logic oe0,
  input wire logic out1,
  input wire logic oe1,
  output logic pin0,
  output logic pin1
);
  // External source holds a level; a driving channel owns the wire
  assign pin0 = oe0 ? out0 : lvl0;
  assign pin1 = oe1 ? out1 : lvl1;
endmodule : cct_pin_model

// ===== cct_timer_test.sv
`timescale 1ns/1ps
module cct_timer_test;
  logic ref_clk, resetn, bus_we, bus_re, lvl0, lvl1;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, d;
  logic [15:0] c, c2, cap;
  wire logic [7:0] bus_rdata;
  wire logic p0, p1, o0, e0, o1, e1, i0, i1, ov;
  integer seed;
  int miscompares, num_checks, v, hi, lo, p, m, e, t;
  cct_timer uut (.ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata),
    .chan0_pin_in(p0), .chan0_pin_out(o0), .chan0_pin_oe(e0), .chan1_pin_in(p1),
    .chan1_pin_out(o1), .chan1_pin_oe(e1), .chan0_irq(i0), .chan1_irq(i1),
    .overflow_irq(ov));
  cct_pin_model pins (.lvl0(lvl0), .lvl1(lvl1), .out0(o0), .oe0(e0), .out1(o1),
    .oe1(e1), .pin0(p0), .pin1(p1));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] w);
    bus_addr <= a;
    bus_wdata <= w;
    bus_we <= 1'b1;
    bus_re <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] r);
    bus_addr <= a;
    bus_we <= 1'b0;
    bus_re <= 1'b1;
    @(posedge ref_clk);
    #1;
    r = bus_rdata;
  endtask : rd
  task idle(input int n);
    bus_we <= 1'b0;
    bus_re <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task wr16(input logic [3:0] a, input logic [15:0] w);
    wr(a, w[15:8]);
    wr(a + 4'h1, w[7:0]);
  endtask : wr16
  task rd16(input logic [3:0] a, output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 4'h1, l);
    r = {h, l};
  endtask : rd16
  task waitlvl(input logic l, output int k);
    k = 0;
    while (o0 !== l) begin
      @(posedge ref_clk);
      #1;
      k++;
      if (k > 600) begin
        miscompares++;
        results();
      end
    end
  endtask : waitlvl
  // Skips settling periods, then times one high and one low phase
  task meas(output int nh, output int nl);
    int k;
    idle(1);
    repeat (3) begin
      waitlvl(1'b0, k);
      waitlvl(1'b1, k);
    end
    waitlvl(1'b0, nh);
    waitlvl(1'b1, nl);
  endtask : meas
  initial begin
    seed = 32'h6167;
    miscompares = 0;
    num_checks = 0;
    resetn = 1'b0;
    bus_we = 1'b0;
    bus_re = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    lvl0 = 1'b0;
    lvl1 = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    resetn <= 1'b1;
    rd16(4'h3, c);
    chk(c, 16'hFFFF);
    rd(4'hF, d);
    chk(d, 8'h00);
    wr16(4'h6, 16'h1234);
    resetn <= 1'b0;
    idle(10);
    resetn <= 1'b1;
    rd16(4'h6, c);
    chk(c, 16'h1234);
    for (p = 0; p < 8; p++) begin
      wr(4'h0, {5'h00, p[2:0]});
      rd16(4'h1, c);
      idle(254);
      rd16(4'h1, c2);
      chk(c2 - c, 16'h0100 >> (p == 7 ? 6 : p));
    end
    wr16(4'h3, 16'h00FF);
    wr(4'h0, 8'h10);
    rd16(4'h1, c);
    idle(298);
    rd16(4'h1, c2);
    chk(c2, {8'h00, c[7:0] + 8'h2C});
    rd(4'h0, d);
    chk(d[7], 1'b1);
    wr(4'h0, 8'hE0);
    idle(3);
    chk(ov, 1'b1);
    rd(4'h0, d);
    wr(4'h0, 8'h60);
    idle(3);
    chk(ov, 1'b0);
    wr(4'h0, 8'h00);
    wr(4'h8, 8'h44);
    lvl1 <= 1'b1;
    idle(6);
    chk(i1, 1'b1);
    for (t = 0; t < 4; t++) begin
      v = t == 0 ? 128 : 1 + {$random(seed)} % 254;
      if (t > 0) begin
        // Smaller value right after the compare, larger one right after the wrap
        waitlvl(v < cap ? 1'b0 : 1'b1, e);
        waitlvl(v < cap ? 1'b1 : 1'b0, e);
      end
      cap = v[15:0];
      for (m = 1; m < 4; m++) begin
        wr16(4'h6, v[15:0]);
        wr(4'h5, {4'h5, m[1:0], 2'b10});
        meas(hi, lo);
        chk(16'(hi + lo), 16'h0100);
        if (m == 1) begin
          chk(hi == v || lo == v, 1'b1);
        end else begin
          chk(16'(hi), 16'(m == 2 ? v : 256 - v));
        end
      end
    end
    chk(i0, 1'b1);
    cap = v[15:0];
    for (e = 1; e < 4; e++) begin
      wr(4'h5, {4'h4, e[1:0], 2'b00});
      idle(6);
      for (t = 0; t < 2; t++) begin
        rd16(4'h1, c);
        lvl0 <= ~lvl0;
        idle(6);
        rd16(4'h6, c2);
        if (lvl0 ? e[0] : e[1]) cap = {8'h00, c[7:0] + 8'h04};
        chk(c2, cap);
      end
    end
    chk(i0, 1'b1);
    wr16(4'h6, 16'h0040);
    wr(4'h5, 8'h3A);
    meas(hi, lo);
    chk(16'(hi), 16'h0040);
    chk(e1, 1'b0);
    chk(o1, 1'b1);
    chk(i1, 1'b0);
    rd(4'h8, d);
    chk(d, 8'h00);
    wr16(4'h9, 16'h00C0);
    meas(hi, lo);
    chk(16'(hi), 16'h00C0);
    wr16(4'h6, 16'h0020);
    meas(hi, lo);
    chk(16'(hi), 16'h0020);
    results();
  end
endmodule : cct_timer_test
